//--- admd_pkg.sv
// Package for the digital microphone and dc-measurement front end
package admd_pkg;

  // ==========================================================
  // Register offsets and field positions
  localparam logic [7:0] OFF_GPIN_CTRL = 8'h33;  // General pin function
  localparam logic [7:0] OFF_DC_CFG    = 8'h66;  // dc_measure_config
  localparam logic [7:0] OFF_DC_LATCH  = 8'h67;  // dc_measure_latch_reset_ctrl
  localparam logic [7:0] OFF_RB_HI     = 8'h68;  // Read-back bits 23:16
  localparam logic [7:0] OFF_RB_MID    = 8'h69;  // Read-back bits 15:8
  localparam logic [7:0] OFF_RB_LO     = 8'h6A;  // Read-back bits 7:0
  localparam logic [7:0] OFF_MIC_CTRL  = 8'h6B;  // Digital mic enable, ratio

  localparam int GPIN_FN_LSB  = 2;
  localparam int GPIN_FN_W    = 4;
  localparam logic [3:0] GPIN_FN_MODCLK = 4'hA;
  localparam int DC_EN_BIT    = 7;
  localparam int DC_MODE_BIT  = 5;
  localparam int LATCH_BIT    = 6;
  localparam int PRST_EN_BIT  = 5;
  localparam int FIELD_W      = 5;
  localparam int MIC_EN_BIT   = 7;

  localparam logic [4:0] LEN_MIN = 5'h01;
  localparam logic [4:0] LEN_MAX = 5'h14;
  localparam int RESULT_W = 24;          // 2.22 fixed point
  localparam int FRAC_W   = 22;

  // Reset values
  localparam logic [7:0] RST_REG   = 8'h00;
  localparam logic [6:0] RST_RATIO = 7'h40;  // Oversampling ratio default

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic       en;
    logic       mode_b;
    logic [4:0] len;
  } admd_cfg_s;

  typedef struct packed {
    logic       latch;
    logic       prst_en;
    logic [4:0] exp_r;
  } admd_latch_s;

  typedef struct packed {
    logic       we;
    logic       re;
    logic [7:0] addr;
    logic [7:0] wdata;
  } admd_reg_req_s;

endpackage

//--- admd_front.sv
// Digital microphone capture and dc-measurement filter, one module
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - Accepts one digital microphone, feeding the mono ADC path, not the analog.
// - Pin function field 1010 drives the modulator clock onto general pin one.
// - Samples microphone bit on each modulator clock rising edge as ADC data.
// - Digital path runs even with analog ADC powered down and bypassed.
// - Config bit 7 enables dc-measurement mode.
// - Result is 24 bits, format 2.22.
// - Result readable at offsets 104 through 106.
// - Software sets latch bit 6; device latches current result into read-back.
// - Config bit 5 selects mode A (zero) or mode B (one).
// - Mode A averages over filter length bits 4:0, valid 1 to 20.
// - Mode B is first-order IIR, coefficient from filter length setting.
// - Periodic reset bit set resets averager every 2^R modulator periods.
// - Periodic reset bit clear means averager resets only at each window end or while dc-measurement is disabled.
// - Decimator reduces modulator-rate samples by the oversampling ratio.
module admd_front import admd_pkg::*; #(
  parameter int DIV_HALF = 4,   // Half period of modulator clock in clk cycles
  parameter int ACC_W    = 32
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Register port
  input  wire logic       reg_we,
  input  wire logic       reg_re,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  // Microphone pins
  input  wire logic       serial_data_in,
  output logic            general_pin_one,
  output logic            general_pin_one_oe_n,
  // Decimated audio stream
  output logic [RESULT_W-1:0] adc_sample,
  output logic                adc_sample_valid
);

  // Divider must fit its counter; accumulator must hold 127 full-scale bits
  if (DIV_HALF < 1 || DIV_HALF > 65535 ||
      ACC_W < RESULT_W + 8) begin : g_bad_param
    $error("admd_front: bad parameters");
  end

  // ==========================================================
  // Registers
  admd_reg_req_s req;
  logic [7:0]  gpin_ctrl, next_gpin_ctrl;
  admd_cfg_s   cfg, next_cfg;
  admd_latch_s lat, next_lat;
  logic        mic_en, next_mic_en;
  logic [6:0]  ratio, next_ratio;
  logic [RESULT_W-1:0] readback, next_readback;
  logic [7:0]  next_rdata;
  logic [RESULT_W-1:0] result;

  assign req = '{we: reg_we, re: reg_re, addr: reg_addr, wdata: reg_wdata};

  // Register writes, read mux and read-back latch
  always_comb begin
    next_gpin_ctrl = gpin_ctrl;
    next_cfg       = cfg;
    next_lat       = lat;
    next_mic_en    = mic_en;
    next_ratio     = ratio;
    next_readback  = readback;
    next_rdata     = reg_rdata;
    if (req.we) begin
      case (req.addr)
        OFF_GPIN_CTRL: next_gpin_ctrl = req.wdata;
        OFF_DC_CFG: begin
          next_cfg.en     = req.wdata[DC_EN_BIT];
          next_cfg.mode_b = req.wdata[DC_MODE_BIT];
          next_cfg.len    = req.wdata[FIELD_W-1:0];
        end
        OFF_DC_LATCH: begin
          next_lat.latch   = req.wdata[LATCH_BIT];
          next_lat.prst_en = req.wdata[PRST_EN_BIT];
          next_lat.exp_r   = req.wdata[FIELD_W-1:0];
        end
        OFF_MIC_CTRL: begin
          next_mic_en = req.wdata[MIC_EN_BIT];
          next_ratio  = req.wdata[6:0];
        end
        default: ;
      endcase
    end
    // Capture on the rising of the latch bit, hold while it stays set
    if (next_lat.latch && !lat.latch) begin
      next_readback = result;
    end
    if (req.re) begin
      case (req.addr)
        OFF_GPIN_CTRL: next_rdata = gpin_ctrl;
        OFF_DC_CFG:    next_rdata = {cfg.en, 1'b0, cfg.mode_b, cfg.len};
        OFF_DC_LATCH:  next_rdata = {1'b0, lat.latch, lat.prst_en, lat.exp_r};
        OFF_RB_HI:     next_rdata = readback[23:16];
        OFF_RB_MID:    next_rdata = readback[15:8];
        OFF_RB_LO:     next_rdata = readback[7:0];
        OFF_MIC_CTRL:  next_rdata = {mic_en, ratio};
        default:       next_rdata = RST_REG;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gpin_ctrl <= RST_REG;
      cfg       <= '0;
      lat       <= '0;
      mic_en    <= 1'b0;
      ratio     <= RST_RATIO;
      readback  <= '0;
      reg_rdata <= RST_REG;
    end else begin
      gpin_ctrl <= next_gpin_ctrl;
      cfg       <= next_cfg;
      lat       <= next_lat;
      mic_en    <= next_mic_en;
      ratio     <= next_ratio;
      readback  <= next_readback;
      reg_rdata <= next_rdata;
    end
  end

  // ==========================================================
  // Modulator clock divider and pin drive
  logic [15:0] div_cnt, next_div_cnt;
  logic        mod_clk, next_mod_clk;
  logic        mod_rise;
  logic        pin_out, next_pin_out;
  logic        pin_oe_n, next_pin_oe_n;
  logic        fn_modclk;

  assign fn_modclk = gpin_ctrl[GPIN_FN_LSB +: GPIN_FN_W] == GPIN_FN_MODCLK;
  assign mod_rise = (div_cnt == 16'(DIV_HALF - 1)) && !mod_clk;

  // Free-running divider; the pin only shows it when routed out
  always_comb begin
    next_div_cnt = div_cnt + 16'h0001;
    next_mod_clk = mod_clk;
    if (div_cnt == 16'(DIV_HALF - 1)) begin
      next_div_cnt = 16'h0000;
      next_mod_clk = ~mod_clk;
    end
    next_pin_out  = fn_modclk & next_mod_clk;
    next_pin_oe_n = ~fn_modclk;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_cnt              <= 16'h0000;
      mod_clk              <= 1'b0;
      general_pin_one      <= 1'b0;
      general_pin_one_oe_n <= 1'b1;
    end else begin
      div_cnt              <= next_div_cnt;
      mod_clk              <= next_mod_clk;
      general_pin_one      <= next_pin_out;
      general_pin_one_oe_n <= next_pin_oe_n;
    end
  end

  // ==========================================================
  // Microphone bit capture through two flip-flops
  logic din_s1, din_s2;
  logic mic_bit, next_mic_bit;
  logic bit_stb, next_bit_stb;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      din_s1 <= 1'b0;
      din_s2 <= 1'b0;
    end else begin
      din_s1 <= serial_data_in;
      din_s2 <= din_s1;
    end
  end

  // Sample only on the modulator rising edge; the mic holds it there
  always_comb begin
    next_mic_bit = mic_bit;
    next_bit_stb = 1'b0;
    if (mod_rise && mic_en) begin
      next_mic_bit = din_s2;
      next_bit_stb = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mic_bit <= 1'b0;
      bit_stb <= 1'b0;
    end else begin
      mic_bit <= next_mic_bit;
      bit_stb <= next_bit_stb;
    end
  end

  // Bit maps to +1.0 or -1.0 in 2.22
  function automatic logic signed [RESULT_W-1:0] bit_val(input logic b);
    bit_val = b ? RESULT_W'(1 << FRAC_W) : -RESULT_W'(1 << FRAC_W);
  endfunction

  // ==========================================================
  // Decimator: integrate-and-dump over the oversampling ratio
  logic signed [ACC_W-1:0] dec_acc, next_dec_acc;
  logic [6:0] dec_cnt, next_dec_cnt;
  logic [RESULT_W-1:0] next_sample;
  logic next_valid;

  // Box-car decimator keeps area small at the cost of alias rejection
  always_comb begin
    next_dec_acc = dec_acc;
    next_dec_cnt = dec_cnt;
    next_sample  = adc_sample;
    next_valid   = 1'b0;
    if (bit_stb) begin
      next_dec_acc = dec_acc + ACC_W'(bit_val(mic_bit));
      next_dec_cnt = dec_cnt + 7'h01;
      if (dec_cnt + 7'h01 >= ratio) begin
        next_sample  = RESULT_W'(next_dec_acc / $signed({1'b0, ratio}));
        next_valid   = 1'b1;
        next_dec_acc = '0;
        next_dec_cnt = 7'h00;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dec_acc          <= '0;
      dec_cnt          <= 7'h00;
      adc_sample       <= '0;
      adc_sample_valid <= 1'b0;
    end else begin
      dec_acc          <= next_dec_acc;
      dec_cnt          <= next_dec_cnt;
      adc_sample       <= next_sample;
      adc_sample_valid <= next_valid;
    end
  end

  // ==========================================================
  // dc-measurement filter
  logic signed [ACC_W-1:0] avg_acc, next_avg_acc;
  logic [20:0] avg_cnt, next_avg_cnt;
  logic [31:0] prst_cnt, next_prst_cnt;
  logic signed [RESULT_W-1:0] dc_res, next_dc_res;
  logic [4:0] len_c;
  logic prst_hit;

  // Out-of-range lengths are clamped so the filter stays defined
  assign len_c = (cfg.len < LEN_MIN) ? LEN_MIN :
                 (cfg.len > LEN_MAX) ? LEN_MAX : cfg.len;
  assign prst_hit = lat.prst_en &&
                    (prst_cnt >= (32'h1 << lat.exp_r) - 32'h1);
  assign result = dc_res;

  // Mode A averages 2^D bits; mode B IIR with coefficient 2^-D
  always_comb begin
    next_avg_acc  = avg_acc;
    next_avg_cnt  = avg_cnt;
    next_prst_cnt = prst_cnt;
    next_dc_res   = dc_res;
    if (!cfg.en) begin
      next_avg_acc  = '0;
      next_avg_cnt  = '0;
      next_prst_cnt = '0;
    end else if (bit_stb) begin
      next_prst_cnt = prst_cnt + 32'h1;
      if (!cfg.mode_b) begin
        // Count signed bits; scaling after keeps long windows in range
        next_avg_acc = mic_bit ? avg_acc + ACC_W'(1)
                               : avg_acc - ACC_W'(1);
        next_avg_cnt = avg_cnt + 21'h1;
        if (avg_cnt + 21'h1 >= (21'h1 << len_c)) begin
          next_dc_res  = RESULT_W'(next_avg_acc <<< (FRAC_W - len_c));
          next_avg_acc = '0;
          next_avg_cnt = '0;
        end
      end else begin
        // Difference spans up to 2.0, so it is formed at the wider ACC_W width
        next_dc_res = dc_res +
          RESULT_W'((ACC_W'(bit_val(mic_bit)) - ACC_W'(dc_res))
                    >>> len_c);
      end
      if (prst_hit) begin
        next_avg_acc  = '0;
        next_avg_cnt  = '0;
        next_prst_cnt = '0;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      avg_acc  <= '0;
      avg_cnt  <= '0;
      prst_cnt <= '0;
      dc_res   <= '0;
    end else begin
      avg_acc  <= next_avg_acc;
      avg_cnt  <= next_avg_cnt;
      prst_cnt <= next_prst_cnt;
      dc_res   <= next_dc_res;
    end
  end

endmodule
`default_nettype wire

//--- admd_front_props.sv
// Checker for the mic front end, seeing only the top module's ports
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Port relations
module admd_front_props import admd_pkg::*; #(
  parameter int DIV_HALF = 4
) (
  input wire logic                clk,
  input wire logic                rst,
  input wire logic                reg_we,
  input wire logic                reg_re,
  input wire logic [7:0]          reg_addr,
  input wire logic [7:0]          reg_wdata,
  input wire logic [7:0]          reg_rdata,
  input wire logic                serial_data_in,
  input wire logic                general_pin_one,
  input wire logic                general_pin_one_oe_n,
  input wire logic [RESULT_W-1:0] adc_sample,
  input wire logic                adc_sample_valid
);
  logic       pin_q;
  logic [7:0] run_len;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Span of the current pin level, saturating so idle stretches stay legal
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_q   <= 1'b0;
      run_len <= 8'h00;
    end else begin
      pin_q   <= general_pin_one;
      run_len <= (general_pin_one != pin_q) ? 8'h01 :
                 run_len + {7'h00, run_len != 8'hFF};
    end
  end
  property p_unmap;
    reg_re && reg_addr == 8'h00 |=> reg_rdata == 8'h00;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_hold;
    !reg_re |=> $stable(reg_rdata);
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_cfg_rd;
    reg_we && reg_addr == OFF_DC_CFG && reg_wdata[4:0] inside {[1:20]}
      ##1 !reg_we ##1 reg_re && reg_addr == OFF_DC_CFG
      |=> reg_rdata == ($past(reg_wdata, 3) & 8'hBF);
  endproperty
  a_cfg_rd: assert property (p_cfg_rd) else $error("config read back");
  property p_oe;
    general_pin_one |-> !general_pin_one_oe_n;
  endproperty
  a_oe: assert property (p_oe) else $error("pin high undriven");
  property p_fnoff;
    reg_we && reg_addr == OFF_GPIN_CTRL && reg_wdata[5:2] != GPIN_FN_MODCLK
      |-> ##[1:3] !general_pin_one;
  endproperty
  a_fnoff: assert property (p_fnoff) else $error("pin kept clocking");
  property p_low;
    general_pin_one && !pin_q |-> run_len >= DIV_HALF;
  endproperty
  a_low: assert property (p_low) else $error("clock low too short");
  property p_high;
    !general_pin_one && pin_q |-> run_len <= DIV_HALF;
  endproperty
  a_high: assert property (p_high) else $error("clock high too long");
  property p_vld;
    adc_sample_valid |=> !adc_sample_valid [*7];
  endproperty
  a_vld: assert property (p_vld) else $error("samples too close");
  property p_smp;
    $changed(adc_sample) |-> adc_sample_valid;
  endproperty
  a_smp: assert property (p_smp) else $error("sample moved alone");
  c_rise: cover property (general_pin_one && !pin_q);
  c_vld:  cover property (adc_sample_valid);
  c_rb:   cover property (reg_re && reg_addr == OFF_RB_HI);
endmodule
bind admd_front admd_front_props #(.DIV_HALF(DIV_HALF)) u_props (
  .clk(clk), .rst(rst), .reg_we(reg_we), .reg_re(reg_re),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .serial_data_in(serial_data_in), .general_pin_one(general_pin_one),
  .general_pin_one_oe_n(general_pin_one_oe_n),
  .adc_sample(adc_sample), .adc_sample_valid(adc_sample_valid));
`default_nettype wire

//--- admd_mic_model.sv
// One-bit digital microphone model
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Microphone
module admd_mic_model (
  input  wire logic mclk,
  input  wire logic level,
  output logic      bit_out
);
  initial bit_out = 1'b1;
  // New bit only after the falling edge, settled around each rise
  always @(negedge mclk) bit_out <= level;
endmodule
`default_nettype wire

//--- admd_front_test.sv
// Register-driven bench for the mic and dc-measurement front end
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Bench top
module admd_front_test import admd_pkg::*; ();
  logic        clk = 0, rst = 1, we = 0, re = 0, lvl = 0;
  logic [7:0]  addr = 0, wd = 0, v, w, rdata;
  logic        pin, oe_n, sdi, vld;
  logic [23:0] smp;
  int          bad_count = 0, n_checks = 0, i;
  // Pulled low while the pin is not driven
  wire mclk = oe_n ? 1'b0 : pin;
  logic [7:0] ra[5] = '{OFF_DC_CFG, OFF_DC_LATCH, OFF_GPIN_CTRL,
                        OFF_MIC_CTRL, 8'h00};
  logic [7:0] rv[5] = '{RST_REG, RST_REG, RST_REG, {1'b0, RST_RATIO}, 8'h00};
  logic [7:0] cf[4] = '{8'h81, 8'h94, 8'hA1, 8'hB4};
  admd_front #(.DIV_HALF(4)) u_dut (.clk(clk), .rst(rst), .reg_we(we),
    .reg_re(re), .reg_addr(addr), .reg_wdata(wd), .reg_rdata(rdata),
    .serial_data_in(sdi), .general_pin_one(pin),
    .general_pin_one_oe_n(oe_n), .adc_sample(smp),
    .adc_sample_valid(vld));
  admd_mic_model u_mic (.mclk(mclk), .level(lvl), .bit_out(sdi));
  initial forever #20 clk = ~clk;
  task automatic chk(input string nm, input logic [7:0] s, e);
    n_checks++;
    if (s !== e) begin
      bad_count++;
      $display("MISMATCH %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(negedge clk);
    we = 1; addr = a; wd = d;
    @(negedge clk);
    we = 0;
  endtask
  // Data lands one edge after the strobe is taken
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    re = 1; addr = a;
    @(negedge clk);
    re = 0;
    @(negedge clk);
    d = rdata;
  endtask
  task automatic rb3(input logic [23:0] e);
    rd(OFF_RB_HI, v); chk("rb_hi", v, e[23:16]);
    rd(OFF_RB_MID, v); chk("rb_mid", v, e[15:8]);
    rd(OFF_RB_LO, v); chk("rb_lo", v, e[7:0]);
  endtask
  task automatic latch_fresh(input logic [7:0] low);
    wr(OFF_DC_LATCH, low);
    wr(OFF_DC_LATCH, low | 8'h40);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    #1200000;
    bad_count++;
    wrap_up;
  end
  // ==========================================================
  // Tests
  initial begin
    repeat (5) @(negedge clk);
    rst = 0;
    chk("pin_rst", {7'h0, oe_n}, 8'h01);
    for (i = 0; i < 5; i++) begin
      rd(ra[i], v); chk("reset_val", v, rv[i]);
    end
    // Enable, both filters, length at both ends of its range
    for (i = 0; i < 4; i++) begin
      wr(OFF_DC_CFG, cf[i]); rd(OFF_DC_CFG, v); chk("cfg", v, cf[i]);
    end
    rd(OFF_RB_HI, v); wr(OFF_RB_HI, ~v);
    rd(OFF_RB_HI, w); chk("rb_ro", w, v);
    // Modulator clock out, mic on with a short ratio
    wr(OFF_GPIN_CTRL, {2'b00, GPIN_FN_MODCLK, 2'b00});
    wr(OFF_MIC_CTRL, 8'h84);
    repeat (4) @(negedge clk);
    chk("oe_on", {7'h0, oe_n}, 8'h00);
    v = 0; w = {7'h0, pin};
    for (i = 0; i < 80; i++) begin
      @(negedge clk);
      if (pin && !w[0]) v++;
      w = {7'h0, pin};
    end
    chk("mclk_rises", v, 8'h0A);
    for (i = 0; i < 1000 && vld !== 1'b1; i++) @(negedge clk);
    chk("vld_seen", {7'h0, vld}, 8'h01);
    repeat (1500) @(negedge clk);
    chk("smp_neg", smp[23:16], 8'hC0);
    lvl = 1;
    repeat (1500) @(negedge clk);
    chk("smp_pos", smp[23:16], 8'h40);
    // Mode A, length 1, mic low then high while latched
    lvl = 0;
    wr(OFF_DC_CFG, 8'h81);
    repeat (400) @(negedge clk);
    latch_fresh(8'h00);
    rb3(24'hC00000);
    lvl = 1;
    repeat (400) @(negedge clk);
    rd(OFF_RB_HI, v); chk("rb_frozen", v, 8'hC0);
    latch_fresh(8'h00);
    rb3(24'h400000);
    // Periodic reset enabled, length below exponent
    latch_fresh(8'h23);
    rd(OFF_DC_LATCH, v); chk("prst", v, 8'h63);
    rb3(24'h400000);
    latch_fresh(8'h00);
    rb3(24'h400000);
    // Mode B swings from plus to minus full scale; only the high read-back byte is checked
    lvl = 0;
    wr(OFF_DC_CFG, 8'hA1);
    repeat (400) @(negedge clk);
    latch_fresh(8'h00);
    rd(OFF_RB_HI, v); chk("iir_hi", v, 8'hC0);
    wr(OFF_DC_LATCH, 8'h00);
    wr(OFF_GPIN_CTRL, 8'h00);
    repeat (8) @(negedge clk);
    chk("pin_off", {6'h0, pin, oe_n}, 8'h01);
    wrap_up;
  end
endmodule
`default_nettype wire
